// >>> design/bms_scheduler.sv
// Purpose: Burst message scheduler with event capture and record store.
// Assumes: Configuration, process values and status come from logic on
//          clk_sys, so they are read without synchronisers.
// Notes:   Periods count half-second ticks; alarms repeat on every tick.
// Function
// - each slot publishes one selected command response.
// - mapped command reports up to eight configured variables in map order.
// - a period not above the computation period is raised above it.
// - continuous mode publishes every update period without a trigger test.
// - window mode publishes when value leaves band around last published.
// - rising mode publishes when value goes above trigger level.
// - falling mode publishes when value drops below trigger level.
// - on-change mode publishes when value moves by the trigger amount.
// - a slot bursts only while its wired burst setting is on.
// - configuration or diagnostic change is an event, alarm repeats.
// - the four most recent events stay readable.
// - three independent slots, each with own settings.
`default_nettype none
module bms_scheduler #(
  parameter int unsigned TICK_CYCLES = bms_pkg::BMS_TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  // Slot settings and live values.
  input  wire bms_pkg::bms_slot_cfg_s slot_cfg [bms_pkg::BMS_SLOTS],
  input  wire bms_pkg::bms_process_s  process,
  input  wire logic [15:0]            diag_status,
  input  wire logic                   cfg_change_pulse,
  input  wire logic                   alarm_ack_pulse,
  // Event record read port.
  input  wire logic [15:0]            ev_rd_number,
  output logic                        ev_rd_hit,
  output bms_pkg::bms_event_s         ev_rd_data,
  output logic [15:0]                 ev_latest_number,
  output logic                        alarm_pending,
  // Message word stream.
  output bms_pkg::bms_word_s          msg_word,
  output logic                        msg_valid,
  input  wire logic                   msg_ready
);
  import bms_pkg::*;

  typedef struct packed {
    logic [24:0]                        pre;
    logic                               tick;
    logic [BMS_SLOTS-1:0][12:0]         cnt;
    logic [BMS_SLOTS-1:0][15:0]         last_pub;
    logic [BMS_SLOTS-1:0]               req;
    logic [15:0]                        diag_last;
    logic [1:0]                         ev_wr;
    logic [15:0]                        ev_num;
    bms_event_s [BMS_EVENTS-1:0]        ev;
    logic                               alarm_pend;
    logic                               alarm_req;
    bms_seq_e                           seq;
    logic [1:0]                         cur;
    logic                               cur_alarm;
    logic [3:0]                         idx;
    bms_word_s                          out;
    bms_word_s                          skid;
    logic                               out_v;
    logic                               skid_v;
    logic                               rd_hit;
    bms_event_s                         rd_data;
  } bms_state_s;

  bms_state_s q;
  bms_state_s d;

  function automatic logic [12:0] eff_period(input logic [3:0] sel);
    logic [12:0] p;
    p = (sel < 4'(BMS_PERIODS)) ? BMS_PERIOD_TICKS[sel]
                                : BMS_PERIOD_TICKS[BMS_PERIODS-1];
    // A period at or below the computation period gains nothing new.
    return (p <= BMS_CALC_TICKS) ? BMS_CALC_TICKS + 13'h0001 : p;
  endfunction

  function automatic logic [15:0] var_val(input bms_var_e v,
                                          input bms_process_s p);
    unique case (v)
      BMS_VAR_PRESSURE: return p.primary_pressure_value;
      BMS_VAR_STATIC:   return p.secondary_static_pressure;
      BMS_VAR_TEMP:     return p.tertiary_capsule_temperature;
      BMS_VAR_PERCENT:  return p.percent_output;
      BMS_VAR_LOOP:     return p.loop_current;
      default:          return 16'h0000;
    endcase
  endfunction

  // Word k of a slot message; also the trigger source when k is zero.
  function automatic logic [15:0] word_val(input bms_slot_cfg_s c,
                                           input bms_process_s p,
                                           input logic [15:0] dg,
                                           input logic [3:0] k);
    unique case (c.cmd)
      BMS_CMD_PCT_LOOP: return (k == 4'h0) ? p.percent_output
                                           : p.loop_current;
      BMS_CMD_DYN_LOOP:
        unique case (k)
          4'h0:    return p.primary_pressure_value;
          4'h1:    return p.loop_current;
          4'h2:    return p.secondary_static_pressure;
          default: return p.tertiary_capsule_temperature;
        endcase
      BMS_CMD_MAPPED:     return var_val(c.var_map[k[2:0]], p);
      BMS_CMD_ADD_STATUS: return dg;
      default:            return p.primary_pressure_value;
    endcase
  endfunction

  function automatic logic [3:0] msg_len(input bms_slot_cfg_s c);
    logic [3:0] n;
    n = 4'h1;
    unique case (c.cmd)
      BMS_CMD_PCT_LOOP: n = 4'h2;
      BMS_CMD_DYN_LOOP: n = 4'h4;
      BMS_CMD_MAPPED:
        for (int i = 0; i < BMS_VARS; i++)
          if (c.var_map[i] != BMS_VAR_UNUSED)
            n = 4'(i + 1);
      default: n = 4'h1;
    endcase
    return n;
  endfunction

  function automatic logic trig_hit(input bms_trig_e t,
                                    input logic signed [15:0] src,
                                    input logic signed [15:0] last,
                                    input logic signed [15:0] lvl);
    logic signed [16:0] df;
    logic signed [16:0] ad;
    df = 17'(src) - 17'(last);
    ad = (df < 0) ? -df : df;
    unique case (t)
      BMS_TRIG_WINDOW:  return ad > 17'(lvl);
      BMS_TRIG_RISING:  return src > lvl;
      BMS_TRIG_FALLING: return src < lvl;
      BMS_TRIG_CHANGE:  return (ad != 17'h0) && (ad >= 17'(lvl));
      default:          return 1'b1;
    endcase
  endfunction

  logic [BMS_SLOTS-1:0] upd_due;
  logic [BMS_SLOTS-1:0] max_due;
  logic [BMS_SLOTS-1:0] hit;
  logic                 any_on;
  logic                 ev_now;
  logic                 push;
  bms_word_s            push_w;
  bms_slot_cfg_s        cc;

  always_comb
  begin
    d      = q;
    any_on = 1'b0;
    cc     = slot_cfg[q.cur];
    d.tick = 1'b0;
    d.pre  = q.pre + 25'h0000001;
    if (q.pre == 25'(TICK_CYCLES - 1))
    begin
      d.pre  = '0;
      d.tick = 1'b1;
    end
    // Each slot keeps its own timer, trigger and request.
    for (int s = 0; s < BMS_SLOTS; s++)
    begin
      // The tick that completes a period is due; waiting for the count to
      // reach the full period would stretch every period by one tick.
      upd_due[s] = q.cnt[s] >= eff_period(slot_cfg[s].upd_idx) - 13'h0001;
      max_due[s] = q.cnt[s] >= eff_period(slot_cfg[s].max_idx) - 13'h0001;
      hit[s] = trig_hit(slot_cfg[s].trig,
                        word_val(slot_cfg[s], process, diag_status, 4'h0),
                        q.last_pub[s], slot_cfg[s].trig_level);
      any_on = any_on | slot_cfg[s].wired_burst_on;
      if (!slot_cfg[s].wired_burst_on)
      begin
        d.cnt[s] = '0;
        d.req[s] = 1'b0;
      end
      else if (q.tick)
      begin
        if (q.cnt[s] != BMS_CNT_MAX)
          d.cnt[s] = q.cnt[s] + 13'h0001;
        if ((upd_due[s] && hit[s]) || max_due[s])
          d.req[s] = 1'b1;
      end
    end
    // Event capture into the record ring.
    ev_now = cfg_change_pulse || (diag_status != q.diag_last);
    d.diag_last = diag_status;
    if (ev_now)
    begin
      d.ev_num          = q.ev_num + 16'h0001;
      d.ev[q.ev_wr]     = '{number: q.ev_num + 16'h0001,
                            cfg_change: cfg_change_pulse,
                            diag: diag_status};
      d.ev_wr           = q.ev_wr + 2'h1;
    end
    // Set wins over acknowledge in the same cycle.
    if (alarm_ack_pulse)
      d.alarm_pend = 1'b0;
    if (ev_now)
      d.alarm_pend = 1'b1;
    if (q.tick && q.alarm_pend && any_on)
      d.alarm_req = 1'b1;
    if (!any_on)
      d.alarm_req = 1'b0;
    // Record read: number zero asks for the latest event.
    d.rd_hit  = 1'b0;
    d.rd_data = '0;
    for (int e = 0; e < BMS_EVENTS; e++)
      if (q.ev_num != BMS_EVNUM_RESET &&
          q.ev[e].number == ((ev_rd_number == 16'h0000) ? q.ev_num
                                                        : ev_rd_number))
      begin
        d.rd_hit  = 1'b1;
        d.rd_data = q.ev[e];
      end
    // Sequencer: alarm first, then the lowest pending slot.
    push   = 1'b0;
    push_w = '0;
    unique case (q.seq)
      BMS_SEQ_IDLE:
      begin
        d.idx = 4'h0;
        if (q.alarm_req)
        begin
          d.alarm_req = 1'b0;
          d.cur_alarm = 1'b1;
          d.seq       = BMS_SEQ_SEND;
        end
        else
          for (int s = BMS_SLOTS - 1; s >= 0; s--)
            if (q.req[s] && slot_cfg[s].wired_burst_on)
            begin
              d.cur_alarm = 1'b0;
              d.cur       = 2'(s);
              d.seq       = BMS_SEQ_SEND;
            end
        if (d.seq == BMS_SEQ_SEND && !d.cur_alarm)
        begin
          d.req[d.cur]      = 1'b0;
          d.cnt[d.cur]      = '0;
          d.last_pub[d.cur] = word_val(slot_cfg[d.cur], process,
                                       diag_status, 4'h0);
        end
      end
      BMS_SEQ_SEND:
      begin
        push         = !q.skid_v;
        push_w.first = (q.idx == 4'h0);
        push_w.alarm = q.cur_alarm;
        push_w.slot  = q.cur;
        push_w.cmd   = q.cur_alarm ? BMS_CMD_ADD_STATUS : cc.cmd;
        if (q.cur_alarm)
        begin
          push_w.last = (q.idx == 4'h1);
          push_w.data = (q.idx == 4'h0) ? q.ev_num : q.diag_last;
        end
        else
        begin
          push_w.last = (q.idx == msg_len(cc) - 4'h1);
          push_w.data = word_val(cc, process, diag_status, q.idx);
        end
        if (push)
        begin
          d.idx = q.idx + 4'h1;
          if (push_w.last)
            d.seq = BMS_SEQ_IDLE;
        end
      end
    endcase
    // Two-entry skid buffer; a stalled reader blocks the sequencer.
    if (!q.out_v || msg_ready)
    begin
      d.out_v  = q.skid_v || push;
      d.out    = q.skid_v ? q.skid : push_w;
      d.skid_v = 1'b0;
    end
    else if (push)
    begin
      d.skid   = push_w;
      d.skid_v = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q        <= '0;
      q.ev_num <= BMS_EVNUM_RESET;
      q.seq    <= BMS_SEQ_IDLE;
    end
    else
      q <= d;
  end

  assign msg_word         = q.out;
  assign msg_valid        = q.out_v;
  assign ev_rd_hit        = q.rd_hit;
  assign ev_rd_data       = q.rd_data;
  assign ev_latest_number = q.ev_num;
  assign alarm_pending    = q.alarm_pend;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_slot_taken;
    q.seq == BMS_SEQ_IDLE && !q.alarm_req && q.req[0] &&
      slot_cfg[0].wired_burst_on;
  endsequence

  sequence s_slot_first_word;
    push && push_w.first && !push_w.alarm && push_w.cmd == cc.cmd &&
      q.cur == 2'h0;
  endsequence

  a_stall_hold: assert property (msg_valid && !msg_ready |=>
    msg_valid && $stable(msg_word))
    else $error("Stalled word changed or dropped.");
  a_off_no_req: assert property (!slot_cfg[0].wired_burst_on |=>
    !q.req[0]) else $error("Disabled slot holds a request.");
  a_cont_publish: assert property (q.tick &&
    slot_cfg[0].wired_burst_on && slot_cfg[0].trig == BMS_TRIG_CONT &&
    upd_due[0] |=> q.req[0] || q.seq == BMS_SEQ_SEND)
    else $error("Continuous slot missed its period.");
  a_max_publish: assert property (q.tick &&
    slot_cfg[0].wired_burst_on && max_due[0] |=>
    q.req[0] || q.seq == BMS_SEQ_SEND)
    else $error("Maximum period passed without publication.");
  a_rise_publish: assert property (q.tick &&
    slot_cfg[0].wired_burst_on && slot_cfg[0].trig == BMS_TRIG_RISING &&
    upd_due[0] && $signed(word_val(slot_cfg[0], process, diag_status,
    4'h0)) > slot_cfg[0].trig_level |=> q.req[0] || q.seq == BMS_SEQ_SEND)
    else $error("Rising level crossing not published.");
  a_fall_nohit: assert property (slot_cfg[0].trig == BMS_TRIG_FALLING &&
    $signed(word_val(slot_cfg[0], process, diag_status, 4'h0)) >=
    slot_cfg[0].trig_level |-> !hit[0])
    else $error("Falling trigger fired above level.");
  a_window_band: assert property (slot_cfg[0].trig == BMS_TRIG_WINDOW &&
    word_val(slot_cfg[0], process, diag_status, 4'h0) == q.last_pub[0] &&
    !slot_cfg[0].trig_level[15] |-> !hit[0])
    else $error("Window trigger fired inside band.");
  a_change_still: assert property (
    slot_cfg[0].trig == BMS_TRIG_CHANGE &&
    word_val(slot_cfg[0], process, diag_status, 4'h0) == q.last_pub[0]
    |-> !hit[0]) else $error("On-change fired without change.");
  a_period_floor: assert property (eff_period(slot_cfg[0].upd_idx) >
    BMS_CALC_TICKS) else $error("Period not above computation period.");
  a_event_count: assert property (ev_now |=>
    q.ev_num == $past(q.ev_num) + 16'h0001 &&
    q.ev[$past(q.ev_wr)].number == q.ev_num)
    else $error("Event not recorded with next number.");
  a_ring_step: assert property (ev_now |=>
    q.ev_wr == $past(q.ev_wr) + 2'h1) else $error("Ring pointer stuck.");
  a_alarm_set: assert property (ev_now |=> alarm_pending)
    else $error("Event did not raise the alarm.");
  // A full skid buffer behind a slow reader may hold the first push back.
  a_slot_first: assert property (s_slot_taken |-> ##[1:8]
    s_slot_first_word) else $error("Slot message did not start.");
  a_mapped_order: assert property (push && !q.cur_alarm &&
    cc.cmd == BMS_CMD_MAPPED |-> push_w.data ==
    var_val(cc.var_map[q.idx[2:0]], process))
    else $error("Mapped variable out of order.");
endmodule
`default_nettype wire

// >>> design/bms_pkg.sv
// Purpose: Shared types and constants of the burst message scheduler.
// Assumes: One 50 MHz clock; process values are signed 16-bit words.
// Notes:   Periods are counted in half-second ticks.
`default_nettype none
package bms_pkg;
  localparam int BMS_SLOTS       = 3;
  localparam int BMS_VARS        = 8;
  localparam int BMS_EVENTS      = 4;
  localparam int BMS_PERIODS     = 14;
  localparam int BMS_CLK_HZ      = 50_000_000;
  localparam int BMS_TICK_MS     = 500;
  localparam int BMS_TICK_CYCLES = BMS_CLK_HZ / 1000 * BMS_TICK_MS;

  // Selectable periods, in half-second ticks: 0.5 s up to 60 min.
  localparam logic [12:0] BMS_PERIOD_TICKS [BMS_PERIODS] = '{
    13'h0001, 13'h0002, 13'h0004, 13'h0008, 13'h0010, 13'h0020, 13'h0040,
    13'h0078, 13'h0258, 13'h04B0, 13'h0708, 13'h0E10, 13'h1518, 13'h1C20};
  // Computation period of the process value, in ticks.
  localparam logic [12:0] BMS_CALC_TICKS   = 13'h0001;
  localparam logic [12:0] BMS_CNT_MAX      = 13'h1FFF;
  localparam logic [15:0] BMS_EVNUM_RESET  = 16'h0000;

  typedef enum logic [2:0] {
    BMS_CMD_PRIMARY, BMS_CMD_PCT_LOOP, BMS_CMD_DYN_LOOP,
    BMS_CMD_MAPPED, BMS_CMD_ADD_STATUS
  } bms_cmd_e;

  typedef enum logic [2:0] {
    BMS_TRIG_CONT, BMS_TRIG_WINDOW, BMS_TRIG_RISING,
    BMS_TRIG_FALLING, BMS_TRIG_CHANGE
  } bms_trig_e;

  typedef enum logic [2:0] {
    BMS_VAR_PRESSURE, BMS_VAR_STATIC, BMS_VAR_TEMP,
    BMS_VAR_PERCENT, BMS_VAR_LOOP, BMS_VAR_UNUSED
  } bms_var_e;

  typedef enum logic {BMS_SEQ_IDLE, BMS_SEQ_SEND} bms_seq_e;

  typedef struct packed {
    logic                          wired_burst_on;
    bms_cmd_e                      cmd;
    bms_trig_e                     trig;
    logic [3:0]                    upd_idx;
    logic [3:0]                    max_idx;
    logic signed [15:0]            trig_level;
    bms_var_e [BMS_VARS-1:0]       var_map;
  } bms_slot_cfg_s;

  typedef struct packed {
    logic signed [15:0] primary_pressure_value;
    logic signed [15:0] secondary_static_pressure;
    logic signed [15:0] tertiary_capsule_temperature;
    logic signed [15:0] percent_output;
    logic signed [15:0] loop_current;
  } bms_process_s;

  typedef struct packed {
    logic        first;
    logic        last;
    logic        alarm;
    logic [1:0]  slot;
    bms_cmd_e    cmd;
    logic [15:0] data;
  } bms_word_s;

  typedef struct packed {
    logic [15:0] number;
    logic        cfg_change;
    logic [15:0] diag;
  } bms_event_s;
endpackage
`default_nettype wire

// >>> verif/bms_host_sink.sv
// Purpose: Host model that takes burst message words off the stream.
// Assumes: A word is taken on clk_sys when valid and ready are both high.
// Notes:   Slow pacing stalls three cycles in four to fill the buffer.
`default_nettype none
module bms_host_sink (
  // Clock.
  input  wire logic               clk_sys,
  // Stream from the scheduler.
  input  wire bms_pkg::bms_word_s msg_word,
  input  wire logic               msg_valid,
  output logic                    msg_ready,
  // Pacing chosen by the bench.
  input  wire logic               slow
);
  timeunit 1ns;
  timeprecision 1ps;
  import bms_pkg::*;
  bms_word_s  got [$];
  logic [1:0] pace;
  // One process owns ready; it moves just after the edge so the scheduler
  // never sees it change at a sampling edge.
  initial
  begin
    pace      = 2'h0;
    msg_ready = 1'b1;
    forever
    begin
      @(posedge clk_sys);
      if (msg_valid && msg_ready)
        got.push_back(msg_word);
      pace      <= pace + 2'h1;
      msg_ready <= #2 !slow || (pace == 2'h3);
    end
  end
endmodule
`default_nettype wire

// >>> verif/burst_message_scheduler_bench.sv
// Purpose: Self-checking bench for the burst message scheduler.
// Assumes: The tick is shortened to four clocks.
// Notes:   Expected words come from the fixed values driven here.
`default_nettype none
module burst_message_scheduler_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import bms_pkg::*;
  localparam int          TK = 4;
  localparam logic [15:0] VP = 16'h0123, VS = 16'h0456, VT = 16'h0789;
  localparam logic [15:0] VC = 16'h0ABC, VL = 16'h0DEF;
  localparam bms_trig_e   TG [4] = '{BMS_TRIG_RISING, BMS_TRIG_FALLING,
                                     BMS_TRIG_WINDOW, BMS_TRIG_CHANGE};
  localparam logic [15:0] LV [4] = '{16'h0064, 16'h0064, 16'h0004, 16'h000A};
  localparam logic [15:0] QV [4] = '{16'h0032, 16'h0078, 16'h0003, 16'h0008};
  localparam logic [15:0] FV [4] = '{16'h0096, 16'h0000, 16'h0005, 16'h0014};
  localparam logic        EC [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  localparam logic [15:0] ED [5] = '{16'h0000, 16'h0000, 16'h0005, 16'h0005,
                                     16'h00A0};
  localparam bms_var_e    MT [8] = '{BMS_VAR_TEMP, BMS_VAR_UNUSED,
    BMS_VAR_LOOP, BMS_VAR_STATIC, BMS_VAR_PERCENT, BMS_VAR_PRESSURE,
    BMS_VAR_UNUSED, BMS_VAR_UNUSED};
  logic          clk_sys, sys_rst, cfg_change_pulse, alarm_ack_pulse, slow;
  logic          ev_rd_hit, alarm_pending, msg_valid, msg_ready;
  logic [15:0]   diag_status, ev_rd_number, ev_latest_number;
  bms_slot_cfg_s slot_cfg [BMS_SLOTS];
  bms_process_s  pv;
  bms_event_s    ev_rd_data;
  bms_word_s     msg_word;
  bms_var_e [BMS_VARS-1:0] vmap;
  logic [15:0]   exp_q [$];
  int            bad_count, total_checks, cyc;

  bms_scheduler #(.TICK_CYCLES(TK)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .slot_cfg(slot_cfg),
    .process(pv), .diag_status(diag_status),
    .cfg_change_pulse(cfg_change_pulse), .alarm_ack_pulse(alarm_ack_pulse),
    .ev_rd_number(ev_rd_number), .ev_rd_hit(ev_rd_hit),
    .ev_rd_data(ev_rd_data), .ev_latest_number(ev_latest_number),
    .alarm_pending(alarm_pending), .msg_word(msg_word),
    .msg_valid(msg_valid), .msg_ready(msg_ready));
  bms_host_sink snk (.clk_sys(clk_sys), .msg_word(msg_word),
    .msg_valid(msg_valid), .msg_ready(msg_ready), .slow(slow));

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic chk_val(input string what, input logic [15:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_word(input string what, input bms_word_s e, g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_ev(input string what, input bms_event_s e, g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic all_off();
    for (int i = 0; i < BMS_SLOTS; i++)
      slot_cfg[i].wired_burst_on = 1'b0;
    step(10 * TK);
    snk.got.delete();
  endtask
  // Burst is switched off around every change so no half-made setting runs.
  task automatic set_slot(input int s, input bms_cmd_e c, input bms_trig_e t,
                          input logic [3:0] m, input logic [15:0] lvl);
    all_off();
    slot_cfg[s] = '{1'b0, c, t, 4'h0, m, lvl, vmap};
    step(1);
    slot_cfg[s].wired_burst_on = 1'b1;
  endtask
  task automatic expect_cmd(input bms_cmd_e c);
    case (c)
      BMS_CMD_PRIMARY:  exp_q = '{VP};
      BMS_CMD_PCT_LOOP: exp_q = '{VC, VL};
      BMS_CMD_DYN_LOOP: exp_q = '{VP, VL, VS, VT};
      BMS_CMD_MAPPED:   exp_q = '{VT, 16'h0000, VL, VS, VC, VP};
      default:          exp_q = '{16'h0000};
    endcase
  endtask
  // The slot field of an alarm message is left open, so it is not judged.
  task automatic take_msg(input logic [1:0] sl, input bms_cmd_e c,
                          input logic al, input int lim);
    bms_word_s w, g;
    int        n;
    n = exp_q.size();
    for (int i = 0; i < lim && snk.got.size() < n; i++)
      step(1);
    chk_val("word count", n[15:0], 16'(snk.got.size()));
    for (int i = 0; i < n && snk.got.size() > 0; i++)
    begin
      g = snk.got.pop_front();
      w = '{i == 0, i == n - 1, al, al ? g.slot : sl, c, exp_q[i]};
      chk_word("message word", w, g);
    end
    exp_q.delete();
  endtask
  task automatic ev_read(input logic [15:0] num, input logic hit,
                         input bms_event_s e);
    ev_rd_number = num;
    step(1);
    chk_val("record hit", {15'h0000, hit}, {15'h0000, ev_rd_hit});
    chk_ev("record", e, ev_rd_data);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    cyc <= cyc + 1;
  initial
  begin
    #200_000;
    bad_count++;
    close_out();
  end
  initial
  begin
    int t0;
    {sys_rst, cfg_change_pulse, alarm_ack_pulse, slow} = 4'h8;
    {diag_status, ev_rd_number} = 32'h0000_0000;
    {bad_count, total_checks, cyc} = '0;
    pv = '{VP, VS, VT, VC, VL};
    foreach (MT[i])
      vmap[i] = MT[i];
    foreach (slot_cfg[i])
      slot_cfg[i] = '0;
    repeat (5) @(posedge clk_sys);
    #2;
    sys_rst = 1'b0;
    step(1);
    chk_val("valid after reset", 16'h0000, {15'h0000, msg_valid});
    chk_val("latest after reset", 16'h0000, ev_latest_number);
    step(6 * TK);
    chk_val("words while off", 16'h0000, 16'(snk.got.size()));
    $display("test reset done");
    for (int i = 0; i < 5; i++)
    begin
      slow = (i >= 2);
      set_slot(i % 3, bms_cmd_e'(i), BMS_TRIG_CONT, 4'h1, 16'h0000);
      expect_cmd(bms_cmd_e'(i));
      take_msg(2'(i % 3), bms_cmd_e'(i), 1'b0, 12 * TK);
    end
    slow = 1'b0;
    $display("test commands done");
    set_slot(1, BMS_CMD_PRIMARY, BMS_TRIG_CONT, 4'hD, 16'h0000);
    expect_cmd(BMS_CMD_PRIMARY);
    take_msg(2'h1, BMS_CMD_PRIMARY, 1'b0, 6 * TK);
    t0 = cyc;
    expect_cmd(BMS_CMD_PRIMARY);
    take_msg(2'h1, BMS_CMD_PRIMARY, 1'b0, 6 * TK);
    // A half-second setting must run at two ticks, one above computation.
    chk_val("raised period", 16'(2 * TK), 16'(cyc - t0));
    $display("test period done");
    for (int i = 0; i < 4; i++)
    begin
      pv.primary_pressure_value = QV[i];
      set_slot(0, BMS_CMD_PRIMARY, TG[i], 4'hD, LV[i]);
      step(6 * TK);
      chk_val("quiet words", 16'h0000, 16'(snk.got.size()));
      pv.primary_pressure_value = FV[i];
      exp_q = '{FV[i]};
      take_msg(2'h0, BMS_CMD_PRIMARY, 1'b0, 6 * TK);
    end
    pv.primary_pressure_value = 16'h0032;
    set_slot(2, BMS_CMD_PRIMARY, BMS_TRIG_RISING, 4'h1, 16'h7FFF);
    exp_q = '{16'h0032};
    take_msg(2'h2, BMS_CMD_PRIMARY, 1'b0, 5 * TK);
    $display("test triggers done");
    all_off();
    for (int i = 0; i < 5; i++)
    begin
      cfg_change_pulse = EC[i];
      diag_status = ED[i];
      step(1);
    end
    cfg_change_pulse = 1'b0;
    chk_val("latest number", 16'h0005, ev_latest_number);
    chk_val("alarm pending", 16'h0001, {15'h0000, alarm_pending});
    ev_read(16'h0000, 1'b1, '{16'h0005, 1'b0, 16'h00A0});
    for (int n = 5; n > 1; n--)
      ev_read(16'(n), 1'b1, '{16'(n), EC[n-1], ED[n-1]});
    ev_read(16'h0001, 1'b0, '0);
    step(6 * TK);
    chk_val("alarm while off", 16'h0000, 16'(snk.got.size()));
    set_slot(0, BMS_CMD_PRIMARY, BMS_TRIG_RISING, 4'hD, 16'h7FFF);
    exp_q = '{16'h0005, 16'h00A0};
    take_msg(2'h0, BMS_CMD_ADD_STATUS, 1'b1, 4 * TK);
    alarm_ack_pulse = 1'b1;
    step(1);
    alarm_ack_pulse = 1'b0;
    chk_val("alarm cleared", 16'h0000, {15'h0000, alarm_pending});
    step(3 * TK);
    snk.got.delete();
    step(6 * TK);
    chk_val("alarm stopped", 16'h0000, 16'(snk.got.size()));
    $display("test events done");
    close_out();
  end
endmodule
`default_nettype wire
